// *** core/psc_dev.sv ***
/*
  protection and soft start controller with its write-only bus target.
  assumes supply flags and pins are asynchronous and the master never stretches.
*/
`timescale 1ns/10ps
`include "psc_map.svh"
module psc_dev #(
  parameter int SS_STEP_CYC = `PSC_SS_STEP_CYC,
  parameter logic [6:0] DEV_ADDR = `PSC_DEV_ADDR
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  psc_i2c_if.dev bus,
  input wire logic supply_ok_83_in,
  input wire logic supply_ok_81_in,
  input wire logic overvoltage_trip_in,
  input wire logic phase_loop_cap_gnd_in,
  output logic line_drive_out,
  output logic supply_drive_out,
  output logic vertical_sawtooth_out_a,
  output logic vertical_sawtooth_out_b,
  output logic lock_loss_out,
  output logic clamp_blank_out,
  output logic phase_loop_cap_pin,
  output logic standby_out,
  output logic reg_wr_out,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_data_out
);
  localparam int CW = $clog2(SS_STEP_CYC + 1);
  generate
    if (SS_STEP_CYC < 1)
    begin : g_chk
      $error("soft start step must be at least one cycle");
    end
  endgenerate

  logic [5:0] raw;
  logic [5:0] s1_r;
  logic [5:0] s2_r;
  logic ok83;
  logic ok81;
  logic trip;
  logic pll_gnd;
  logic scl;
  logic sda;
  logic scl_d_r;
  logic sda_d_r;
  logic start_c;
  logic stop_c;
  logic rise_c;
  logic fall_c;
  psc_pkg::psc_phase_t phase_r;
  logic [3:0] bitcnt_r;
  logic [7:0] shift_r;
  logic [7:0] sub_r;
  logic ack_r;
  logic ack_c;
  logic sda_oe_r;
  logic decide_c;
  logic data_ok_c;
  logic ctrl_wr_c;
  logic soft_start_bit_r;
  logic seen_r;
  logic overvoltage_trip_in_lat_r;
  logic dip_lat_r;
  logic protect_r;
  logic [2:0] stage_r;
  logic [CW-1:0] step_r;

  // two-flop sync of every pin input
  assign raw = {bus.scl, bus.sda, phase_loop_cap_gnd_in, overvoltage_trip_in, supply_ok_81_in, supply_ok_83_in};
  generate
    for (genvar i = 0; i < 6; i++)
    begin : g_sync
      always_ff @(posedge mclk_in or negedge nrst_in)
      begin
        if (!nrst_in)
        begin
          s1_r[i] <= (i >= 4); // bus lines idle high, no false edge
          s2_r[i] <= (i >= 4);
        end
        else
        begin
          s1_r[i] <= raw[i];
          s2_r[i] <= s1_r[i];
        end
      end
    end
  endgenerate
  assign {scl, sda, pll_gnd, trip, ok81, ok83} = s2_r;

  // bus edge and condition detection
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_d_r <= scl;
      sda_d_r <= sda;
    end
  end
  assign start_c = scl & scl_d_r & sda_d_r & ~sda;
  assign stop_c = scl & scl_d_r & ~sda_d_r & sda;
  assign rise_c = scl & ~scl_d_r;
  assign fall_c = ~scl & scl_d_r;
  assign decide_c = fall_c & (bitcnt_r == 4'h8) & ~start_c & ~stop_c;

  // acknowledge decision for the byte just received
  always_comb
  begin
    data_ok_c = ok83 & (~protect_r | (sub_r == `PSC_SUB_CTRL));
    case (phase_r)
      psc_pkg::PSC_PH_ADDR: ack_c = ok83 & (shift_r[7:1] == DEV_ADDR) & ~shift_r[0];
      psc_pkg::PSC_PH_SUB: ack_c = ok83;
      psc_pkg::PSC_PH_DATA: ack_c = data_ok_c;
      default: ack_c = 1'b0;
    endcase
  end
  assign ctrl_wr_c = decide_c & ack_c & (phase_r == psc_pkg::PSC_PH_DATA) & (sub_r == `PSC_SUB_CTRL);

  // byte framing and acknowledge drive
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      phase_r <= psc_pkg::PSC_PH_IDLE;
      bitcnt_r <= 4'h0;
      shift_r <= 8'h00;
      sub_r <= 8'h00;
      ack_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end
    else if (start_c)
    begin
      phase_r <= psc_pkg::PSC_PH_ADDR;
      bitcnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
    end
    else if (stop_c)
    begin
      phase_r <= psc_pkg::PSC_PH_IDLE;
      sda_oe_r <= 1'b0;
    end
    else if (rise_c && bitcnt_r < 4'h8)
    begin
      shift_r <= {shift_r[6:0], sda};
      bitcnt_r <= bitcnt_r + 4'h1;
    end
    else if (decide_c)
    begin
      ack_r <= ack_c;
      sda_oe_r <= ack_c;
      bitcnt_r <= 4'h9;
      if (phase_r == psc_pkg::PSC_PH_SUB)
        sub_r <= shift_r;
    end
    else if (fall_c && bitcnt_r == 4'h9)
    begin
      sda_oe_r <= 1'b0; // release after ack slot
      bitcnt_r <= 4'h0;
      case (phase_r)
        psc_pkg::PSC_PH_ADDR: phase_r <= ack_r ? psc_pkg::PSC_PH_SUB : psc_pkg::PSC_PH_SKIP;
        psc_pkg::PSC_PH_SUB: phase_r <= ack_r ? psc_pkg::PSC_PH_DATA : psc_pkg::PSC_PH_SKIP;
        psc_pkg::PSC_PH_DATA:
        begin
          sub_r <= sub_r + 8'h01; // next byte to next subaddress
          phase_r <= ack_r ? psc_pkg::PSC_PH_DATA : psc_pkg::PSC_PH_SKIP;
        end
        default: phase_r <= phase_r;
      endcase
    end
  end
  assign bus.sda_d_oe = sda_oe_r;

  // register write strobe, only for acknowledged data
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      reg_wr_out <= 1'b0;
      reg_addr_out <= 8'h00;
      reg_data_out <= 8'h00;
    end
    else
    begin
      reg_wr_out <= decide_c & ack_c & (phase_r == psc_pkg::PSC_PH_DATA);
      if (decide_c && ack_c && phase_r == psc_pkg::PSC_PH_DATA)
      begin
        reg_addr_out <= sub_r;
        reg_data_out <= shift_r;
      end
    end
  end

  // soft start bit and first-data flag
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      soft_start_bit_r <= 1'b0;
      seen_r <= 1'b0;
    end
    else
    begin
      if (!ok83)
        soft_start_bit_r <= 1'b0;
      else if (ctrl_wr_c)
        soft_start_bit_r <= shift_r[`PSC_CTRL_SS_BIT];
      if (decide_c && ack_c && phase_r == psc_pkg::PSC_PH_DATA)
        seen_r <= 1'b1;
    end
  end

  // per-cause protection latches, set wins over clear
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      overvoltage_trip_in_lat_r <= 1'b0;
      dip_lat_r <= 1'b0;
    end
    else
    begin
      if (trip)
        overvoltage_trip_in_lat_r <= 1'b1;
      else if (ctrl_wr_c && shift_r[`PSC_CTRL_SS_BIT])
        overvoltage_trip_in_lat_r <= 1'b0;
      if (!ok81 && !protect_r)
        dip_lat_r <= 1'b1;
      else if (!ok83 || (ctrl_wr_c && shift_r[`PSC_CTRL_SS_BIT]))
        dip_lat_r <= 1'b0;
    end
  end

  // protection mode; grounded loop pin only while held
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      protect_r <= 1'b1;
    else
      protect_r <= ~ok83 | ~seen_r | ~soft_start_bit_r | trip | overvoltage_trip_in_lat_r | dip_lat_r | pll_gnd;
  end

  // soft start stage sequencer
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      stage_r <= 3'h0;
      step_r <= '0;
    end
    else if (protect_r)
    begin
      stage_r <= 3'h0;
      step_r <= '0;
    end
    else if (stage_r != `PSC_SS_LAST)
    begin
      if (step_r == CW'(SS_STEP_CYC - 1))
      begin
        step_r <= '0;
        stage_r <= stage_r + 3'h1;
      end
      else
        step_r <= step_r + CW'(1);
    end
  end

  // pin states: 1 means driving, lock loss 1 means floating
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      clamp_blank_out <= 1'b1;
      phase_loop_cap_pin <= 1'b1;
      line_drive_out <= 1'b0;
      supply_drive_out <= 1'b0;
      vertical_sawtooth_out_a <= 1'b0;
      vertical_sawtooth_out_b <= 1'b0;
      lock_loss_out <= 1'b1;
      standby_out <= 1'b1;
    end
    else
    begin
      clamp_blank_out <= protect_r | (stage_r < 3'h1);
      phase_loop_cap_pin <= protect_r | (stage_r < 3'h1);
      line_drive_out <= ~protect_r & (stage_r >= 3'h2);
      supply_drive_out <= ~protect_r & (stage_r >= 3'h3);
      vertical_sawtooth_out_a <= ~protect_r & (stage_r >= 3'h4);
      vertical_sawtooth_out_b <= ~protect_r & (stage_r >= 3'h4);
      lock_loss_out <= protect_r | (stage_r < `PSC_SS_LAST);
      standby_out <= protect_r;
    end
  end
endmodule : psc_dev

// *** core/psc_map.svh ***
/*
  constants of the protection and soft start controller and its bus master.
  assumes a 20 MHz mclk_in on both ends and one target address on the bus.
*/
// How it works
// - drives stay off until supply and data
// - no acknowledge and standby below 8.3 V
// - low supply clears the soft start bit
// - above 8.3 V every register may be loaded outside standby
// - setting soft start releases the drive outputs
// - dip below 8.1 V enters protection, floats lock
// - trip latches protection until soft start rewrite
// - grounded loop pin holds protection while grounded
// - dip recovery needs reload and soft start
// - low supply recovery needs supply, reload, soft start
// - protection floats line and supply drives
// - protection floats the lock loss output
// - protection blanks clamp output, discharges loop capacitor
// - soft start releases actions in fixed order
// - standby acknowledges data only at control subaddress
// - standby nacks other data, data not stored
// - probe data acknowledged only when active
// - master sends first data to control subaddress
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH
`define PSC_CLK_NS 50
`define PSC_CLK_MHZ 20
`define PSC_DEV_ADDR 7'h46
`define PSC_SUB_CTRL 8'h1a
`define PSC_SUB_PROBE 8'h00
`define PSC_CTRL_SS_BIT 0
`define PSC_CTRL_STBY_BIT 1
`define PSC_SS_STEP_US 20
`define PSC_SS_STEP_CYC (`PSC_SS_STEP_US * `PSC_CLK_MHZ)
`define PSC_SS_LAST 3'h5
`define PSC_I2C_BIT_NS 10000
`define PSC_I2C_QTR_CYC (`PSC_I2C_BIT_NS / `PSC_CLK_NS / 4)
`define PSC_FRAME_BITS 27
`endif

// *** core/psc_pkg.sv ***
/*
  types shared by both ends of the controller link.
  assumes psc_map.svh for the numbers.
*/
package psc_pkg;
  typedef enum logic [4:0] {
    PSC_PH_IDLE = 5'b00001,
    PSC_PH_ADDR = 5'b00010,
    PSC_PH_SUB = 5'b00100,
    PSC_PH_DATA = 5'b01000,
    PSC_PH_SKIP = 5'b10000
  } psc_phase_t;
  typedef enum logic [3:0] {
    PSC_HS_IDLE = 4'b0001,
    PSC_HS_START = 4'b0010,
    PSC_HS_BITS = 4'b0100,
    PSC_HS_STOP = 4'b1000
  } psc_hstate_t;
endpackage : psc_pkg

// *** core/psc_i2c_if.sv ***
/*
  open-drain two-wire bus between the controller and its master.
  assumes pull-ups: a line is high unless some end enables its driver.
*/
`timescale 1ns/10ps
interface psc_i2c_if;
  logic scl_m_oe;
  logic sda_m_oe;
  logic sda_d_oe;
  logic scl;
  logic sda;
  // wired-and with pull-up
  assign scl = ~scl_m_oe;
  assign sda = ~(sda_m_oe | sda_d_oe);
  modport dev (input scl, input sda, output sda_d_oe);
  modport host (input scl, input sda, output scl_m_oe, output sda_m_oe);
endinterface : psc_i2c_if

// *** core/psc_host.sv ***
/*
  bus master that writes one byte to one subaddress per command.
  assumes the target never stretches the clock; acks are reported, not acted on.
*/
`timescale 1ns/10ps
`include "psc_map.svh"
module psc_host #(
  parameter int QTR_CYC = `PSC_I2C_QTR_CYC,
  parameter logic [6:0] DEV_ADDR = `PSC_DEV_ADDR
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  psc_i2c_if.host bus,
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_sub_in,
  input wire logic [7:0] cmd_data_in,
  output logic cmd_ready_out,
  output logic done_out,
  output logic ack_addr_out,
  output logic ack_sub_out,
  output logic ack_data_out
);
  localparam int QW = $clog2(QTR_CYC + 1);
  generate
    if (QTR_CYC < 4)
    begin : g_chk
      $error("quarter bit must cover the target's input sync");
    end
  endgenerate

  psc_pkg::psc_hstate_t st_r;
  logic [QW-1:0] qcnt_r;
  logic [1:0] q_r;
  logic [4:0] idx_r;
  logic [26:0] tx_r;
  logic scl_oe_r;
  logic sda_oe_r;
  logic s1_r;
  logic sda_s_r;
  logic tick;

  // two-flop sync of the data line
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      s1_r <= 1'b1;
      sda_s_r <= 1'b1;
    end
    else
    begin
      s1_r <= bus.sda;
      sda_s_r <= s1_r;
    end
  end

  // quarter-bit timer
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      qcnt_r <= '0;
    else if (st_r == psc_pkg::PSC_HS_IDLE || tick)
      qcnt_r <= '0;
    else
      qcnt_r <= qcnt_r + QW'(1);
  end
  assign tick = (qcnt_r == QW'(QTR_CYC - 1));

  // frame sequencer: start, 27 bits with three ack slots, stop
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      st_r <= psc_pkg::PSC_HS_IDLE;
      q_r <= 2'h0;
      idx_r <= 5'h00;
      tx_r <= '0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      cmd_ready_out <= 1'b0;
      done_out <= 1'b0;
      ack_addr_out <= 1'b0;
      ack_sub_out <= 1'b0;
      ack_data_out <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      case (st_r)
        psc_pkg::PSC_HS_IDLE:
        begin
          cmd_ready_out <= 1'b1;
          if (cmd_valid_in && cmd_ready_out)
          begin
            cmd_ready_out <= 1'b0;
            tx_r <= {DEV_ADDR, 1'b0, 1'b1, cmd_sub_in, 1'b1, cmd_data_in, 1'b1};
            q_r <= 2'h0;
            idx_r <= 5'h00;
            st_r <= psc_pkg::PSC_HS_START;
          end
        end
        psc_pkg::PSC_HS_START:
          if (tick)
          begin
            q_r <= q_r + 2'h1;
            if (q_r == 2'h1)
              sda_oe_r <= 1'b1; // data falls with clock high
            if (q_r == 2'h3)
            begin
              scl_oe_r <= 1'b1;
              st_r <= psc_pkg::PSC_HS_BITS;
            end
          end
        psc_pkg::PSC_HS_BITS:
          if (tick)
          begin
            q_r <= q_r + 2'h1;
            case (q_r)
              2'h0: sda_oe_r <= ~tx_r[26];
              2'h1: scl_oe_r <= 1'b0;
              2'h2:
              begin
                if (idx_r == 5'd8)
                  ack_addr_out <= ~sda_s_r;
                if (idx_r == 5'd17)
                  ack_sub_out <= ~sda_s_r;
                if (idx_r == 5'd26)
                  ack_data_out <= ~sda_s_r;
              end
              default:
              begin
                scl_oe_r <= 1'b1;
                tx_r <= {tx_r[25:0], 1'b1};
                idx_r <= idx_r + 5'h01;
                if (idx_r == 5'(`PSC_FRAME_BITS - 1))
                  st_r <= psc_pkg::PSC_HS_STOP;
              end
            endcase
          end
        psc_pkg::PSC_HS_STOP:
          if (tick)
          begin
            q_r <= q_r + 2'h1;
            case (q_r)
              2'h0: sda_oe_r <= 1'b1;
              2'h1: scl_oe_r <= 1'b0;
              2'h2: sda_oe_r <= 1'b0; // data rises with clock high
              default:
              begin
                done_out <= 1'b1;
                st_r <= psc_pkg::PSC_HS_IDLE;
              end
            endcase
          end
        default: st_r <= psc_pkg::PSC_HS_IDLE;
      endcase
    end
  end
  assign bus.scl_m_oe = scl_oe_r;
  assign bus.sda_m_oe = sda_oe_r;
endmodule : psc_host

// *** verification/psc_checker.sv ***
/*
  assertions on the link and the controller pins.
  assumes it sits beside the link interface in the testbench.
*/
`timescale 1ns/10ps
module psc_checker (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic sda_d_oe,
  input wire logic supply_ok_83_in,
  input wire logic supply_ok_81_in,
  input wire logic overvoltage_trip_in,
  input wire logic phase_loop_cap_gnd_in,
  input wire logic line_drive_out,
  input wire logic supply_drive_out,
  input wire logic vertical_sawtooth_out_a,
  input wire logic vertical_sawtooth_out_b,
  input wire logic lock_loss_out,
  input wire logic clamp_blank_out,
  input wire logic phase_loop_cap_pin,
  input wire logic standby_out,
  input wire logic reg_wr_out,
  input wire logic [7:0] reg_addr_out
);
  logic any_drive;
  // any power output active
  assign any_drive = line_drive_out | supply_drive_out | vertical_sawtooth_out_a | vertical_sawtooth_out_b;
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);
  // supply, trip and grounded loop pin causes
  drives_off_a : assert property (!supply_ok_83_in [*6] |-> !any_drive && lock_loss_out)
    else $error("drive active on low supply");
  no_ack_a : assert property (!supply_ok_83_in [*6] |-> !sda_d_oe)
    else $error("acknowledge on low supply");
  dip_hold_a : assert property (!supply_ok_81_in [*6] |-> standby_out && lock_loss_out)
    else $error("dip left protection off");
  trip_hold_a : assert property (overvoltage_trip_in [*6] |-> standby_out)
    else $error("trip left protection off");
  loop_hold_a : assert property (phase_loop_cap_gnd_in [*6] |-> standby_out)
    else $error("grounded loop pin left protection off");
  // protection pin states
  float_a : assert property (standby_out [*2] |-> !any_drive && lock_loss_out)
    else $error("drive not floating in protection");
  blank_a : assert property (standby_out [*2] |-> clamp_blank_out && phase_loop_cap_pin)
    else $error("no blanking or discharge in protection");
  // release sequence order and standby store address
  line_order_a : assert property ($rose(line_drive_out) |-> !clamp_blank_out && !supply_drive_out)
    else $error("line drive out of order");
  supply_order_a : assert property ($rose(supply_drive_out) |-> line_drive_out && !vertical_sawtooth_out_a)
    else $error("supply drive out of order");
  lock_order_a : assert property ($fell(lock_loss_out) |-> vertical_sawtooth_out_b && supply_drive_out)
    else $error("lock loss released out of order");
  standby_wr_a : assert property (reg_wr_out && standby_out |-> reg_addr_out == 8'h1a)
    else $error("store in standby outside control");
endmodule : psc_checker

// *** verification/testbench.sv ***
/*
  self-checking bench: controller and bus master joined by the link.
  assumes the map header on the include path and a 20 MHz clock.
*/
`timescale 1ns/10ps
`include "psc_map.svh"
module testbench;
  localparam logic [7:0] PROT = 8'h0f;
  localparam logic [7:0] RUN = 8'hf0;
  logic mclk_in, nrst_in, ok83, ok81, trip, gnd, cmd_valid, ready, done, reg_wr;
  logic line, sup, saw_a, saw_b, lock, blank, dis, stby;
  logic [7:0] cmd_sub, cmd_data, reg_addr, reg_data, outs;
  logic [2:0] acks;
  int bad_count = 0;
  int samples_checked = 0;
  int wr_count = 0;
  psc_i2c_if bus ();
  psc_dev #(.SS_STEP_CYC(4)) u_psc_dev (.mclk_in(mclk_in), .nrst_in(nrst_in), .bus(bus),
    .supply_ok_83_in(ok83), .supply_ok_81_in(ok81), .overvoltage_trip_in(trip), .phase_loop_cap_gnd_in(gnd),
    .line_drive_out(line), .supply_drive_out(sup), .vertical_sawtooth_out_a(saw_a),
    .vertical_sawtooth_out_b(saw_b), .lock_loss_out(lock), .clamp_blank_out(blank), .phase_loop_cap_pin(dis),
    .standby_out(stby), .reg_wr_out(reg_wr), .reg_addr_out(reg_addr), .reg_data_out(reg_data));
  psc_host #(.QTR_CYC(8)) u_psc_host (.mclk_in(mclk_in), .nrst_in(nrst_in), .bus(bus),
    .cmd_valid_in(cmd_valid), .cmd_sub_in(cmd_sub), .cmd_data_in(cmd_data), .cmd_ready_out(ready),
    .done_out(done), .ack_addr_out(acks[2]), .ack_sub_out(acks[1]), .ack_data_out(acks[0]));
  psc_checker chk (.mclk_in(mclk_in), .nrst_in(nrst_in), .sda_d_oe(bus.sda_d_oe), .supply_ok_83_in(ok83),
    .supply_ok_81_in(ok81), .overvoltage_trip_in(trip), .phase_loop_cap_gnd_in(gnd), .line_drive_out(line),
    .supply_drive_out(sup), .vertical_sawtooth_out_a(saw_a), .vertical_sawtooth_out_b(saw_b),
    .lock_loss_out(lock), .clamp_blank_out(blank), .phase_loop_cap_pin(dis), .standby_out(stby),
    .reg_wr_out(reg_wr), .reg_addr_out(reg_addr));
  // pin states as one vector
  assign outs = {line, sup, saw_a, saw_b, lock, blank, dis, stby};
  // free-running clock
  initial
  begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end
  // count stored bytes
  always @(posedge mclk_in)
  begin
    if (reg_wr === 1'b1)
      wr_count <= wr_count + 1;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check
  task automatic close_out();
    if (bad_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : tick
  // one write frame, acks and storage judged
  task automatic send(input logic [7:0] sub, input logic [7:0] dat, input logic [2:0] exp);
    int n;
    int w0;
    w0 = wr_count;
    n = 0;
    while (ready !== 1'b1 && n < 50)
    begin
      tick(1);
      n++;
    end
    if (n >= 50)
    begin
      bad_count++;
      $display("unexpected at %0t: master never ready", $time);
      close_out();
    end
    @(posedge mclk_in);
    cmd_valid <= 1'b1;
    cmd_sub <= sub;
    cmd_data <= dat;
    @(posedge mclk_in);
    cmd_valid <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 1500)
    begin
      tick(1);
      n++;
    end
    if (n >= 1500)
    begin
      bad_count++;
      $display("unexpected at %0t: frame never ended", $time);
      close_out();
    end
    check({5'h00, acks}, {5'h00, exp}, "acks");
    check(8'(wr_count - w0), {7'h00, exp[0]}, "stored bytes");
    if (exp[0])
    begin
      check(reg_addr, sub, "stored subaddress");
      check(reg_data, dat, "stored data");
    end
  endtask : send
  task automatic restart();
    send(`PSC_SUB_CTRL, 8'h01, 3'b111);
    tick(40);
    check(outs, RUN, "after soft start");
  endtask : restart
  task automatic t_low_supply();
    send(`PSC_SUB_CTRL, 8'h01, 3'b000);
    check(outs, PROT, "low supply");
  endtask : t_low_supply
  task automatic t_first_write();
    @(posedge mclk_in);
    ok83 <= 1'b1;
    tick(20);
    check(outs, PROT, "before data");
    send(8'h05, 8'h55, 3'b110);
    restart();
    send(`PSC_SUB_PROBE, 8'h33, 3'b111);
  endtask : t_first_write
  task automatic t_trip();
    @(posedge mclk_in);
    trip <= 1'b1;
    tick(10);
    check(outs, PROT, "trip");
    @(posedge mclk_in);
    trip <= 1'b0;
    tick(40);
    check(outs, PROT, "trip latched");
    restart();
  endtask : t_trip
  task automatic t_loop_gnd();
    @(posedge mclk_in);
    gnd <= 1'b1;
    tick(10);
    check(outs, PROT, "loop grounded");
    send(8'h07, 8'h21, 3'b110);
    @(posedge mclk_in);
    gnd <= 1'b0;
    tick(40);
    check(outs, RUN, "loop released");
  endtask : t_loop_gnd
  task automatic t_dip();
    @(posedge mclk_in);
    ok81 <= 1'b0;
    tick(10);
    check(outs, PROT, "dip");
    send(`PSC_SUB_PROBE, 8'h44, 3'b110);
    @(posedge mclk_in);
    ok81 <= 1'b1;
    tick(40);
    check(outs, PROT, "dip latched");
    restart();
  endtask : t_dip
  task automatic t_low_clear();
    @(posedge mclk_in);
    ok83 <= 1'b0;
    tick(10);
    check(outs, PROT, "supply fall");
    @(posedge mclk_in);
    ok83 <= 1'b1;
    tick(40);
    check(outs, PROT, "soft start bit cleared");
    restart();
  endtask : t_low_clear
  // main sequence
  initial
  begin
    nrst_in = 1'b0;
    ok83 = 1'b0;
    ok81 = 1'b1;
    trip = 1'b0;
    gnd = 1'b0;
    cmd_valid = 1'b0;
    cmd_sub = 8'h00;
    cmd_data = 8'h00;
    repeat (20) @(posedge mclk_in);
    nrst_in <= 1'b1;
    tick(4);
    t_low_supply();
    t_first_write();
    t_trip();
    t_loop_gnd();
    t_dip();
    t_low_clear();
    close_out();
  end
endmodule : testbench
